// ---- inc/pwtc_defines.svh ----
// register offsets, field positions and codes of the pwm trigger and logic block
// assumes one 40 MHz clock and an apb register bus with 12-bit byte addresses
`ifndef PWTC_DEFINES_SVH
`define PWTC_DEFINES_SVH
`define PWTC_CNT_W 16
`define PWTC_GROUP 4
`define PWTC_GEN_REGION 4'h0
`define PWTC_LOGIC_REGION 7'h08
`define PWTC_OFF_CTRL 5'h00
`define PWTC_OFF_PERIOD 5'h04
`define PWTC_OFF_DUTY 5'h08
`define PWTC_OFF_EVENT 5'h0c
`define PWTC_OFF_STATUS 5'h10
`define PWTC_B_ENABLE 15
`define PWTC_B_SYNCEN 9
`define PWTC_B_SWTRIG 8
`define PWTC_B_RETRIG 6
`define PWTC_F_CYCLE_START_SELECT 3:0
`define PWTC_F_TSEL 2:0
`define PWTC_B_INV 6
`define PWTC_F_LF 5:4
`define PWTC_F_DEST 2:0
`define PWTC_F_SRC1 10:8
`define PWTC_F_SRC2 14:12
`define PWTC_CYCLE_START_SELECT_LOCAL 4'h0
`define PWTC_CYCLE_START_SELECT_PEER_LO 4'h1
`define PWTC_CYCLE_START_SELECT_PEER_HI 4'h4
`define PWTC_CYCLE_START_SELECT_SWONLY 4'hf
`define PWTC_LF_OR 2'h0
`define PWTC_LF_AND 2'h1
`define PWTC_LF_XOR 2'h2
`define PWTC_DEST_NONE 3'h0
`define PWTC_TSEL_EOC 3'h0
`define PWTC_TSEL_MID 3'h1
`define PWTC_CNT_ZERO 16'h0000
`define PWTC_CNT_ONE 16'h0001
`define PWTC_RST_PERIOD 16'h00ff
`define PWTC_RST_DUTY 16'h0080
`endif

// ---- inc/pwtc_pkg.sv ----
// types shared by the pwm trigger and logic block
// assumes the defines header is on the include path
`include "pwtc_defines.svh"
package pwtc_pkg;
    typedef enum logic {PWTC_IDLE, PWTC_RUN} pwtc_state_t;
    typedef struct packed {
        logic enable;
        logic sync_en;
        logic retrig;
        logic [3:0] cycle_start_select;
        logic [2:0] tsel;
        logic [`PWTC_CNT_W-1:0] period;
        logic [`PWTC_CNT_W-1:0] duty;
    } pwtc_gen_cfg_t;
    typedef struct packed {
        logic [2:0] src_two;
        logic [2:0] src_one;
        logic inv;
        logic [1:0] lf;
        logic [2:0] dest;
    } pwtc_logic_cfg_t;
endpackage

// ---- hw/pwtc_logic_cell.sv ----
// one combinatorial logic instance: optional inversion of source two, then or/and/xor
// assumes sources are already tied low when their channel is absent
`include "pwtc_defines.svh"
module pwtc_logic_cell (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_src_one,
    input wire logic i_src_two,
    input wire pwtc_pkg::pwtc_logic_cfg_t i_cfg,
    output logic o_result,
    output logic o_active
);
    import pwtc_pkg::*;
    wire logic src_two_pol = i_src_two ^ i_cfg.inv;
    wire logic res_or = i_src_one | src_two_pol;
    wire logic res_and = i_src_one & src_two_pol;
    wire logic res_xor = i_src_one ^ src_two_pol;
    // reserved function code yields zero
    assign o_result = (i_cfg.lf == `PWTC_LF_XOR) ? res_xor :
                      (i_cfg.lf == `PWTC_LF_AND) ? res_and :
                      (i_cfg.lf == `PWTC_LF_OR) ? res_or : 1'b0;
    assign o_active = (i_cfg.dest != `PWTC_DEST_NONE);

    property p_logic_inv;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.lf == `PWTC_LF_AND && i_src_one && i_cfg.inv) |-> (o_result == !i_src_two);
    endproperty
    a_logic_inv: assert property (p_logic_inv) else $error("source two not inverted");

    property p_logic_func;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.lf == `PWTC_LF_XOR && !i_cfg.inv) |-> (o_result == (i_src_one != i_src_two));
    endproperty
    a_logic_func: assert property (p_logic_func) else $error("xor function wrong");
endmodule

// ---- hw/pwtc_top.sv ----
// pwm generator array: start-of-cycle selection, trigger modes and combinatorial pin logic
// assumes an apb master on i_clk_sys and sync inputs from a foreign clock domain
`include "pwtc_defines.svh"
// Operation
// - source-two invert bit inverts the second logic input before combining
// - function code 10 xor, 01 and, 00 or; 11 reserved
// - destination 001..111 drives generator two..eight pins; 000 disables
// - a logic input selecting an absent generator reads constant zero
// - six independent logic instances, each with own settings
// - retrigger select one means retriggerable, zero means single trigger
// - start select 1111: only software trigger or sync starts; 0101..1110 reserved
// - start select 0001..0100 takes peer one..four trigger output of group
// - start select 0000 restarts generator on its own end of cycle
// - enabled sync input is ored with the selected start source
// - foreign-domain start sources pass a synchroniser into generator clock
// - generators grouped in fours; triggers only inside own group
module pwtc_top #(
    parameter int NUM_GEN = 8,
    parameter int NUM_IMPL = 8,
    parameter int NUM_LOGIC = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_GEN-1:0] i_sync_async,
    output logic [NUM_GEN-1:0] o_pwm_high,
    output logic [NUM_GEN-1:0] o_pwm_low
);
    import pwtc_pkg::*;

    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic [NUM_GEN-1:0] pwm_high_ff;
    logic [NUM_GEN-1:0] pwm_low_ff;
    logic [NUM_GEN-1:0] nxt_pwm_high;
    logic [NUM_GEN-1:0] nxt_pwm_low;
    pwtc_gen_cfg_t gen_cfg_ff [NUM_GEN];
    pwtc_logic_cfg_t logic_cfg_ff [NUM_LOGIC];
    pwtc_state_t state_ff [NUM_GEN];
    logic [`PWTC_CNT_W-1:0] cnt_ff [NUM_GEN];
    logic [NUM_GEN-1:0] swtrig_ff;
    logic [NUM_GEN-1:0] sync1_ff;
    logic [NUM_GEN-1:0] sync2_ff;
    logic [NUM_GEN-1:0] sync3_ff;
    logic [NUM_GEN-1:0] run;
    logic [NUM_GEN-1:0] eoc;
    logic [NUM_GEN-1:0] software_trigger_bit_out;
    logic [NUM_GEN-1:0] peer_software_trigger_bit;
    logic [NUM_GEN-1:0] sync_rise;
    logic [NUM_GEN-1:0] start;
    logic [NUM_GEN-1:0] raw_high;
    logic [NUM_LOGIC-1:0] logic_res;
    logic [NUM_LOGIC-1:0] logic_act;

    // apb decode
    wire logic acc_phase = i_psel & i_penable & ~pready_ff;
    wire logic wr_en = i_psel & i_penable & pready_ff & i_pwrite & ~pslverr_ff;
    wire logic [2:0] gen_idx = i_paddr[7:5];
    wire logic [4:0] reg_off = i_paddr[4:0];
    wire logic [2:0] logic_idx = i_paddr[4:2];
    wire logic in_gen = (i_paddr[11:8] == `PWTC_GEN_REGION) & (32'(gen_idx) < NUM_GEN);
    wire logic in_logic = (i_paddr[11:5] == `PWTC_LOGIC_REGION) & (32'(logic_idx) < NUM_LOGIC)
                          & (i_paddr[1:0] == 2'h0);
    wire logic gen_reg_ok = (reg_off == `PWTC_OFF_CTRL) | (reg_off == `PWTC_OFF_PERIOD)
                            | (reg_off == `PWTC_OFF_DUTY) | (reg_off == `PWTC_OFF_EVENT)
                            | (reg_off == `PWTC_OFF_STATUS);
    wire logic gen_hit = in_gen & gen_reg_ok;
    wire logic [15:0] wdata = i_pwdata[15:0];

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = ~(gen_hit | in_logic);
        if (gen_hit) begin
            unique case (reg_off)
                `PWTC_OFF_CTRL: begin
                    nxt_prdata[`PWTC_B_ENABLE] = gen_cfg_ff[gen_idx].enable;
                    nxt_prdata[`PWTC_B_SYNCEN] = gen_cfg_ff[gen_idx].sync_en;
                    nxt_prdata[`PWTC_B_RETRIG] = gen_cfg_ff[gen_idx].retrig;
                    nxt_prdata[`PWTC_F_CYCLE_START_SELECT] = gen_cfg_ff[gen_idx].cycle_start_select;
                end
                `PWTC_OFF_PERIOD: nxt_prdata[`PWTC_CNT_W-1:0] = gen_cfg_ff[gen_idx].period;
                `PWTC_OFF_DUTY: nxt_prdata[`PWTC_CNT_W-1:0] = gen_cfg_ff[gen_idx].duty;
                `PWTC_OFF_EVENT: nxt_prdata[`PWTC_F_TSEL] = gen_cfg_ff[gen_idx].tsel;
                default: nxt_prdata = {15'h0000, run[gen_idx], cnt_ff[gen_idx]};
            endcase
        end else if (in_logic) begin
            nxt_prdata[`PWTC_F_SRC2] = logic_cfg_ff[logic_idx].src_two;
            nxt_prdata[`PWTC_F_SRC1] = logic_cfg_ff[logic_idx].src_one;
            nxt_prdata[`PWTC_B_INV] = logic_cfg_ff[logic_idx].inv;
            nxt_prdata[`PWTC_F_LF] = logic_cfg_ff[logic_idx].lf;
            nxt_prdata[`PWTC_F_DEST] = logic_cfg_ff[logic_idx].dest;
        end
    end

    // answer one cycle into the access phase
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= acc_phase;
            pslverr_ff <= acc_phase & nxt_pslverr;
            prdata_ff <= (acc_phase & ~i_pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_prdata = prdata_ff;

    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g++) begin : gen_pg
            localparam int GBASE = (g / `PWTC_GROUP) * `PWTC_GROUP;
            localparam bit IMPL = (g < NUM_IMPL);
            wire logic wr_gen = wr_en & gen_hit & (32'(gen_idx) == g);
            wire logic [3:0] cycle_start_select = gen_cfg_ff[g].cycle_start_select;
            wire logic peer_sel = (cycle_start_select >= `PWTC_CYCLE_START_SELECT_PEER_LO) & (cycle_start_select <= `PWTC_CYCLE_START_SELECT_PEER_HI);
            wire logic [1:0] peer_ofs = 2'(cycle_start_select - `PWTC_CYCLE_START_SELECT_PEER_LO);
            wire logic hw_start;
            wire logic gen_on = gen_cfg_ff[g].enable & IMPL;

            assign run[g] = (state_ff[g] == PWTC_RUN);
            assign eoc[g] = run[g] & (cnt_ff[g] == gen_cfg_ff[g].period);
            assign software_trigger_bit_out[g] = IMPL & (((gen_cfg_ff[g].tsel == `PWTC_TSEL_EOC) & eoc[g])
                                 | ((gen_cfg_ff[g].tsel == `PWTC_TSEL_MID) & run[g]
                                 & (cnt_ff[g] == gen_cfg_ff[g].duty)));
            // peer index stays inside the own group of four
            assign peer_software_trigger_bit[g] = peer_sel & software_trigger_bit_out[GBASE + 32'(peer_ofs)];
            assign hw_start = (cycle_start_select == `PWTC_CYCLE_START_SELECT_LOCAL) ? (eoc[g] | ~run[g]) :
                              peer_software_trigger_bit[g];
            assign sync_rise[g] = sync2_ff[g] & ~sync3_ff[g];
            assign start[g] = gen_on & (hw_start | swtrig_ff[g]
                              | (gen_cfg_ff[g].sync_en & sync_rise[g]));
            assign raw_high[g] = run[g] & (cnt_ff[g] < gen_cfg_ff[g].duty);

            // two-flop synchroniser, third flop for the edge
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                    sync3_ff[g] <= 1'b0;
                end else begin
                    sync1_ff[g] <= i_sync_async[g];
                    sync2_ff[g] <= sync1_ff[g];
                    sync3_ff[g] <= sync2_ff[g];
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    gen_cfg_ff[g] <= '{enable: 1'b0, sync_en: 1'b0, retrig: 1'b0,
                                      cycle_start_select: `PWTC_CYCLE_START_SELECT_LOCAL, tsel: `PWTC_TSEL_EOC,
                                      period: `PWTC_RST_PERIOD, duty: `PWTC_RST_DUTY};
                    swtrig_ff[g] <= 1'b0;
                end else begin
                    swtrig_ff[g] <= wr_gen & (reg_off == `PWTC_OFF_CTRL) & wdata[`PWTC_B_SWTRIG];
                    if (wr_gen & (reg_off == `PWTC_OFF_CTRL)) begin
                        gen_cfg_ff[g].enable <= wdata[`PWTC_B_ENABLE];
                        gen_cfg_ff[g].sync_en <= wdata[`PWTC_B_SYNCEN];
                        gen_cfg_ff[g].retrig <= wdata[`PWTC_B_RETRIG];
                        gen_cfg_ff[g].cycle_start_select <= wdata[`PWTC_F_CYCLE_START_SELECT];
                    end
                    if (wr_gen & (reg_off == `PWTC_OFF_PERIOD)) begin
                        gen_cfg_ff[g].period <= wdata;
                    end
                    if (wr_gen & (reg_off == `PWTC_OFF_DUTY)) begin
                        gen_cfg_ff[g].duty <= wdata;
                    end
                    if (wr_gen & (reg_off == `PWTC_OFF_EVENT)) begin
                        gen_cfg_ff[g].tsel <= wdata[`PWTC_F_TSEL];
                    end
                end
            end

            // cycle sequencer
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n || !gen_on) begin
                    state_ff[g] <= PWTC_IDLE;
                    cnt_ff[g] <= `PWTC_CNT_ZERO;
                end else if (start[g] & (~run[g] | eoc[g] | gen_cfg_ff[g].retrig)) begin
                    state_ff[g] <= PWTC_RUN;
                    cnt_ff[g] <= `PWTC_CNT_ZERO;
                end else if (eoc[g]) begin
                    state_ff[g] <= PWTC_IDLE;
                    cnt_ff[g] <= `PWTC_CNT_ZERO;
                end else if (run[g]) begin
                    cnt_ff[g] <= cnt_ff[g] + `PWTC_CNT_ONE;
                end
            end

            property p_retrig;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (gen_on && run[g] && !eoc[g] && start[g] && gen_cfg_ff[g].retrig)
                |=> (run[g] && cnt_ff[g] == `PWTC_CNT_ZERO);
            endproperty
            a_retrig: assert property (p_retrig) else $error("retrigger did not restart");

            property p_single;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (gen_on && run[g] && !eoc[g] && !gen_cfg_ff[g].retrig && $stable(gen_cfg_ff[g]))
                |=> (cnt_ff[g] == $past(cnt_ff[g]) + `PWTC_CNT_ONE);
            endproperty
            a_single: assert property (p_single) else $error("single mode cycle disturbed");

            property p_self;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (gen_on && cycle_start_select == `PWTC_CYCLE_START_SELECT_LOCAL && eoc[g]) |=> (run[g] && cnt_ff[g] == `PWTC_CNT_ZERO);
            endproperty
            a_self: assert property (p_self) else $error("no self restart on end of cycle");

            property p_swonly;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (gen_on && !run[g] && cycle_start_select == `PWTC_CYCLE_START_SELECT_SWONLY && !swtrig_ff[g]
                 && !(gen_cfg_ff[g].sync_en && sync_rise[g])) |=> !run[g];
            endproperty
            a_swonly: assert property (p_swonly) else $error("hardware source started cycle");

            property p_peer;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (gen_on && !run[g] && peer_sel && software_trigger_bit_out[GBASE + 32'(peer_ofs)]) |=> run[g];
            endproperty
            a_peer: assert property (p_peer) else $error("peer trigger not taken");

            property p_sync;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (gen_on && !run[g] && gen_cfg_ff[g].sync_en && $rose(sync2_ff[g])) |=> run[g];
            endproperty
            a_sync: assert property (p_sync) else $error("sync did not start cycle");
        end
    endgenerate

    // combinatorial logic instances
    genvar y;
    generate
        for (y = 0; y < NUM_LOGIC; y++) begin : gen_logic
            wire logic [2:0] s1 = logic_cfg_ff[y].src_one;
            wire logic [2:0] s2 = logic_cfg_ff[y].src_two;
            wire logic src_one = (32'(s1) < NUM_IMPL) ? raw_high[s1] : 1'b0;
            wire logic src_two = (32'(s2) < NUM_IMPL) ? raw_high[s2] : 1'b0;
            wire logic wr_log = wr_en & in_logic & (32'(logic_idx) == y);

            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    logic_cfg_ff[y] <= '{src_two: 3'h0, src_one: 3'h0, inv: 1'b0,
                                        lf: `PWTC_LF_OR, dest: `PWTC_DEST_NONE};
                end else if (wr_log) begin
                    logic_cfg_ff[y].src_two <= wdata[`PWTC_F_SRC2];
                    logic_cfg_ff[y].src_one <= wdata[`PWTC_F_SRC1];
                    logic_cfg_ff[y].inv <= wdata[`PWTC_B_INV];
                    logic_cfg_ff[y].lf <= wdata[`PWTC_F_LF];
                    logic_cfg_ff[y].dest <= wdata[`PWTC_F_DEST];
                end
            end

            pwtc_logic_cell u_cell (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_src_one(src_one),
                .i_src_two(src_two),
                .i_cfg(logic_cfg_ff[y]),
                .o_result(logic_res[y]),
                .o_active(logic_act[y])
            );

            property p_absent;
                @(posedge i_clk_sys) disable iff (!i_rst_n)
                (32'(s1) >= NUM_IMPL) |-> !src_one;
            endproperty
            a_absent: assert property (p_absent) else $error("absent source not zero");
        end
    endgenerate

    // pin steering, higher instance wins on a shared destination
    always_comb begin
        nxt_pwm_high = raw_high;
        nxt_pwm_low = ~raw_high & run;
        for (int k = 0; k < NUM_LOGIC; k++) begin
            if (logic_act[k] && 32'(logic_cfg_ff[k].dest) < NUM_IMPL) begin
                nxt_pwm_high[logic_cfg_ff[k].dest] = logic_res[k];
                nxt_pwm_low[logic_cfg_ff[k].dest] = ~logic_res[k];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pwm_high_ff <= '0;
            pwm_low_ff <= '0;
        end else begin
            pwm_high_ff <= nxt_pwm_high;
            pwm_low_ff <= nxt_pwm_low;
        end
    end

    assign o_pwm_high = pwm_high_ff;
    assign o_pwm_low = pwm_low_ff;

    property p_dest;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (logic_act[NUM_LOGIC-1] && 32'(logic_cfg_ff[NUM_LOGIC-1].dest) < NUM_IMPL)
        |=> (o_pwm_high[$past(logic_cfg_ff[NUM_LOGIC-1].dest)] == $past(logic_res[NUM_LOGIC-1]));
    endproperty
    a_dest: assert property (p_dest) else $error("logic result not on destination pin");

    property p_ready;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_psel && !i_penable) ##1 (i_psel && i_penable) |=> o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer late");
endmodule

// ---- tb/pwtc_sync_src.sv ----
// foreign-domain start source that drives the per-generator sync inputs
// assumes requests come from the bench; its clock is unrelated to the system clock
module pwtc_sync_src (
    input wire logic [7:0] i_fire,
    output logic [7:0] o_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_far = 1'b0;
    always #16.3 clk_far = ~clk_far;
    initial o_sync = 8'h00;
    // edges come from a foreign clock, so the block must synchronise them
    always @(posedge clk_far) begin
        o_sync <= i_fire;
    end
endmodule

// ---- tb/pwtc_top_tb.sv ----
// self-checking bench of the pwm trigger and logic block
// assumes the defines header and package are compiled first
module pwtc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd_v;
    logic pready;
    logic pslverr;
    logic err_v;
    logic [7:0] fire = 8'h00;
    logic [7:0] sync_async;
    logic [7:0] pwm_high;
    logic [7:0] pwm_low;
    int n_fail = 0;
    int n_checks = 0;
    logic [1:0] lf_t [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
    logic [2:0] s2_t [6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h7};
    logic inv_t [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic exp_t [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

    always #12.5 clk = ~clk;

    pwtc_top #(.NUM_GEN(8), .NUM_IMPL(7), .NUM_LOGIC(6)) i_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sync_async(sync_async),
        .o_pwm_high(pwm_high), .o_pwm_low(pwm_low)
    );
    pwtc_sync_src i_src (.i_fire(fire), .o_sync(sync_async));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one apb transfer; read data and error taken at the pready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task st(input int g);
        apb(1'b0, 12'(g * 32 + 16), 32'h0);
    endtask

    task wait_run(input int g, input logic exp);
        int k;
        k = 0;
        st(g);
        while (rd_v[16] !== exp && k < 150) begin
            k++;
            st(g);
        end
    endtask

    task t_reset;
        apb(1'b0, 12'h000, 32'h0);
        check(rd_v, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd_v, 32'h00ff);
        apb(1'b0, 12'h008, 32'h0);
        check(rd_v, 32'h0080);
        apb(1'b0, 12'h100, 32'h0);
        check(rd_v, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        check(err_v, 1'b1);
        check(rd_v, 32'h0);
        apb(1'b1, 12'h118, 32'h1);
        check(err_v, 1'b1);
        apb(1'b1, 12'h010, 32'hffff);
        st(0);
        check(rd_v, 32'h0);
    endtask

    task t_modes;
        apb(1'b1, 12'h004, 32'h0028);
        apb(1'b1, 12'h008, 32'hffff);
        apb(1'b1, 12'h000, 32'h800f);
        repeat (10) @(posedge clk);
        st(0);
        check(rd_v[16], 1'b0);
        apb(1'b1, 12'h000, 32'h810f);
        repeat (10) @(posedge clk);
        apb(1'b1, 12'h000, 32'h810f);
        st(0);
        check({rd_v[16], rd_v[15:0] > 10}, 2'b11);
        @(negedge clk);
        check(pwm_high[0], 1'b1);
        wait_run(0, 1'b0);
        check(rd_v[16], 1'b0);
        apb(1'b1, 12'h000, 32'h814f);
        repeat (10) @(posedge clk);
        apb(1'b1, 12'h000, 32'h814f);
        st(0);
        check({rd_v[16], rd_v[15:0] < 8}, 2'b11);
        wait_run(0, 1'b0);
    endtask

    task t_peer;
        apb(1'b1, 12'h004, 32'h0005);
        apb(1'b1, 12'h000, 32'h800f);
        apb(1'b1, 12'h020, 32'h8001);
        apb(1'b1, 12'h02c, 32'h0001);
        apb(1'b1, 12'h040, 32'h8002);
        apb(1'b1, 12'h080, 32'h8001);
        apb(1'b1, 12'h060, 32'h8009);
        apb(1'b1, 12'h000, 32'h810f);
        wait_run(1, 1'b1);
        check(rd_v[16], 1'b1);
        wait_run(2, 1'b1);
        check(rd_v[16], 1'b1);
        st(4);
        check(rd_v[16], 1'b0);
        st(3);
        check(rd_v[16], 1'b0);
    endtask

    task t_sync;
        apb(1'b1, 12'h060, 32'h820f);
        apb(1'b1, 12'h0a0, 32'h800f);
        @(posedge clk);
        fire <= 8'h28;
        wait_run(3, 1'b1);
        check(rd_v[16], 1'b1);
        st(5);
        check(rd_v[16], 1'b0);
    endtask

    task t_logic;
        apb(1'b1, 12'h020, 32'h0);
        apb(1'b1, 12'h040, 32'h0);
        apb(1'b1, 12'h000, 32'h8000);
        apb(1'b1, 12'h0e8, 32'hffff);
        apb(1'b1, 12'h0e0, 32'h8000);
        repeat (20) @(posedge clk);
        st(0);
        check(rd_v[16], 1'b1);
        for (int y = 0; y < 6; y++) begin
            apb(1'b1, 12'(12'h100 + 4 * y), {17'h0, s2_t[y], 4'h0, 1'b0, inv_t[y], lf_t[y], 1'b0, 3'(y + 1)});
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
        for (int y = 0; y < 6; y++) begin
            check({pwm_high[y + 1], pwm_low[y + 1]}, {exp_t[y], !exp_t[y]});
        end
        apb(1'b1, 12'h104, 32'h1110);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({pwm_high[2], pwm_low[2]}, 2'b00);
        apb(1'b1, 12'h104, 32'h1032);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({pwm_high[2], pwm_low[2]}, 2'b01);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_modes();
        t_peer();
        t_sync();
        t_logic();
        conclude();
    end

    initial begin
        #(25 * 40000);
        n_fail++;
        conclude();
    end
endmodule
